// ---- bench/host_field_model.sv ----
/*
 Host and field stand-in driving the supply manager pins.
 Assumes commands from the bench, sampled on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module host_field_model (
	input wire logic mclk,
	input wire logic fieldOn,
	input wire logic selectOn,
	input wire logic writeOn,
	output logic fieldPowerGood,
	output logic slaveSelectN,
	output logic memWriteBusy
);
	// ********************************************
	// Pin drive
	// ********************************************
	initial begin
		fieldPowerGood = 1'b0;
		slaveSelectN = 1'b1;
		memWriteBusy = 1'b0;
	end
	// No clocking, only field power, selects and writes
	always @(posedge mclk) begin
		fieldPowerGood <= #1 fieldOn;
		slaveSelectN <= #1 !selectOn;
		memWriteBusy <= #1 writeOn;
	end
endmodule : host_field_model
`default_nettype wire

// ---- bench/supply_source_manager_tb_top.sv ----
/*
 Self-checking bench for the supply source manager.
 Assumes short hold-off and startup parameters.
*/
`timescale 1ns/100ps
`default_nettype none
module supply_source_manager_tb_top;
	localparam int HOLD = 20;
	localparam int START = 4;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic fieldOn = 1'b0;
	logic selectOn = 1'b0;
	logic writeOn = 1'b0;
	logic fieldPowerGood, slaveSelectN, memWriteBusy, coreReady;
	supply_source_pkg::supplySel_t supplySel;
	logic [7:0] bufferDepth;
	logic [15:0] lfsr = 16'hc510;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;

	always #12.5 mclk = ~mclk;

	host_field_model host_field_model_inst (.mclk(mclk), .fieldOn(fieldOn),
		.selectOn(selectOn), .writeOn(writeOn), .fieldPowerGood(fieldPowerGood),
		.slaveSelectN(slaveSelectN), .memWriteBusy(memWriteBusy));
	supply_source_manager #(.HOLDOFF_CYCLES(HOLD), .STARTUP_CYCLES(START))
		supply_source_manager_inst (.mclk(mclk), .arst_n(arst_n),
		.fieldPowerGood(fieldPowerGood), .slaveSelectN(slaveSelectN),
		.memWriteBusy(memWriteBusy), .supplySel(supplySel), .coreReady(coreReady),
		.bufferDepth(bufferDepth));

	// ********************************************
	// Helpers
	// ********************************************
	function automatic supply_source_pkg::supplySel_t exp_sel(input logic f, input logic s);
		return f ? 3'b010 : (s ? 3'b001 : 3'b100);
	endfunction : exp_sel

	task automatic check_sel(input string what, input supply_source_pkg::supplySel_t exp);
		checks_done++;
		if (supplySel !== exp) begin
			errors++;
			$display("unexpected %s: expected %b seen %b", what, exp, supplySel);
		end
	endtask : check_sel

	task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check_val

	// Commands land one step after the edge; outputs are settled by then
	task automatic apply(input logic f, input logic s, input logic w, input int n);
		fieldOn = f;
		selectOn = s;
		writeOn = w;
		repeat (n) @(posedge mclk);
		#1;
	endtask : apply

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	always @(posedge mclk) begin
		cycles++;
		if (cycles > 4000) begin
			errors++;
			print_verdict();
		end
	end

	// ********************************************
	// Sequence
	// ********************************************
	initial begin
		logic f;
		logic s;
		repeat (3) @(posedge mclk);
		#1;
		check_sel("reset sel", 3'b100);
		check_val("reset ready", 8'h00, {7'h0, coreReady});
		arst_n = 1'b1;
		apply(0, 0, 0, 2);
		check_val("depth", 8'h20, bufferDepth);
		apply(0, 1, 0, 8);
		check_sel("host on", 3'b001);
		apply(0, 1, 0, 8);
		check_val("host ready", 8'h01, {7'h0, coreReady});
		apply(0, 0, 0, HOLD);
		check_sel("hold", 3'b001);
		apply(0, 0, 0, 12);
		check_sel("release", 3'b100);
		check_val("off ready", 8'h00, {7'h0, coreReady});
		apply(0, 1, 1, 12);
		apply(0, 0, 1, HOLD + 12);
		check_sel("write hold", 3'b001);
		apply(0, 0, 0, HOLD + 12);
		check_sel("write done", 3'b100);
		apply(0, 1, 0, 12);
		apply(1, 1, 0, 8);
		check_sel("field wins", 3'b010);
		check_val("field ready", 8'h01, {7'h0, coreReady});
		apply(1, 0, 0, 8);
		check_sel("field only", 3'b010);
		// Long dwell per step so the hold-off never masks a transition
		repeat (24) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			f = lfsr[0];
			s = lfsr[1];
			apply(f, s, 0, HOLD + 12);
			check_sel("random sel", exp_sel(f, s));
			check_val("random ready", {7'h0, f | s}, {7'h0, coreReady});
		end
		print_verdict();
	end
endmodule : supply_source_manager_tb_top
`default_nettype wire

// ---- verilog/input_sync3.sv ----
/*
 Three-stage synchroniser with agreement filter.
 Assumes a level input from outside the mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module input_sync3 #(
	parameter logic RESET_VALUE = 1'b0
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic din,
	output logic dout
);
	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic out_reg;
	logic out_next;

	always_comb begin
		stage_next = {stage_reg[1:0], din};
		// Only stages two and three are looked at, never the first
		out_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : out_reg;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stage_reg <= {3{RESET_VALUE}};
			out_reg <= RESET_VALUE;
		end else begin
			stage_reg <= stage_next;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule : input_sync3
`default_nettype wire

// ---- verilog/supply_source_manager.sv ----
/*
 Core supply source selection: off, field rail or host serial rail.
 Assumes mclk is an always-running timebase and the switches are external.
*/
// Functional notes
// [R1] No field, select high: core disconnected
// [R2] Field power good connects field rail
// [R3] Field rail preferred; host rail fallback
// [R4] Host switch only without field, select low
// [R5] Host switch held 0.7ms after release
// [R6] Host switch held through memory writes
// [R7] Host waits 50us before first clock
// [R8] Host limits itself to memory, registers
// [R9] Power-good detector has hysteresis, analog
// [R10] Serial side has 32-byte buffer
// [R11] Memory reachable from both sides
// [R12] Hold-off counted from always-on timebase
`timescale 1ns/100ps
`default_nettype none
`include "supply_source_manager_defines.svh"
module supply_source_manager #(
	parameter int HOLDOFF_CYCLES = `SSM_HOLDOFF_CYCLES,
	parameter int STARTUP_CYCLES = `SSM_STARTUP_CYCLES,
	parameter int BUFFER_BYTES = 32
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic fieldPowerGood,
	input wire logic slaveSelectN,
	input wire logic memWriteBusy,
	output supply_source_pkg::supplySel_t supplySel,
	output logic coreReady,
	output logic [7:0] bufferDepth
);
	localparam int CW = $clog2(HOLDOFF_CYCLES + STARTUP_CYCLES + 2);

	// ********************************************
	// Input conditioning
	// ********************************************
	supply_source_pkg::supplyIn_t syncIn;

	// [R9] Clean field indication
	input_sync3 #(.RESET_VALUE(1'b0)) u_syncField (
		.mclk(mclk),
		.arst_n(arst_n),
		.din(fieldPowerGood),
		.dout(syncIn.fieldPowerGood)
	);

	input_sync3 #(.RESET_VALUE(1'b1)) u_syncSelect (
		.mclk(mclk),
		.arst_n(arst_n),
		.din(slaveSelectN),
		.dout(syncIn.slaveSelectN)
	);

	// Write busy comes from logic on mclk
	assign syncIn.memWriteBusy = memWriteBusy;

	// ********************************************
	// State machine
	// ********************************************
	supply_source_pkg::supplyState_t state_reg;
	supply_source_pkg::supplyState_t state_next;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	supply_source_pkg::supplySel_t sel_reg;
	supply_source_pkg::supplySel_t sel_next;
	logic ready_reg;
	logic ready_next;

	function automatic supply_source_pkg::supplySel_t selFor(
		input supply_source_pkg::supplyState_t st);
		supply_source_pkg::supplySel_t s;
		s = '{coreOff: 1'b1, fieldSwitch: 1'b0, hostSwitch: 1'b0};
		case (st)
			supply_source_pkg::SUPPLY_FIELD: begin
				s = '{coreOff: 1'b0, fieldSwitch: 1'b1, hostSwitch: 1'b0};
			end
			supply_source_pkg::SUPPLY_HOST, supply_source_pkg::SUPPLY_HOLD: begin
				s = '{coreOff: 1'b0, fieldSwitch: 1'b0, hostSwitch: 1'b1};
			end
			default: begin
				s = '{coreOff: 1'b1, fieldSwitch: 1'b0, hostSwitch: 1'b0};
			end
		endcase
		return s;
	endfunction : selFor

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		ready_next = ready_reg;
		case (state_reg)
			supply_source_pkg::SUPPLY_OFF: begin
				ready_next = 1'b0;
				// [R2] Field rail first
				if (syncIn.fieldPowerGood) begin
					state_next = supply_source_pkg::SUPPLY_FIELD;
					ready_next = 1'b1;
				// [R4] Host rail on select low
				end else if (!syncIn.slaveSelectN) begin
					state_next = supply_source_pkg::SUPPLY_HOST;
					count_next = '0;
				end
			end
			supply_source_pkg::SUPPLY_FIELD: begin
				// [R1] Field lost: host rail if select low, else core off
				if (!syncIn.fieldPowerGood) begin
					ready_next = 1'b0;
					if (!syncIn.slaveSelectN) begin
						state_next = supply_source_pkg::SUPPLY_HOST;
						count_next = '0;
					end else begin
						state_next = supply_source_pkg::SUPPLY_OFF;
					end
				end
			end
			supply_source_pkg::SUPPLY_HOST: begin
				// [R7] Buffer charge time before core ready
				if (count_reg < CW'(STARTUP_CYCLES)) begin
					count_next = count_reg + CW'(1);
				end else begin
					ready_next = 1'b1;
				end
				// [R3] Field rail takes over when available
				if (syncIn.fieldPowerGood) begin
					state_next = supply_source_pkg::SUPPLY_FIELD;
					ready_next = 1'b1;
				end else if (syncIn.slaveSelectN && !syncIn.memWriteBusy) begin
					state_next = supply_source_pkg::SUPPLY_HOLD;
					count_next = '0;
				end
			end
			default: begin
				// [R12] Hold-off counted on mclk
				count_next = count_reg + CW'(1);
				if (syncIn.fieldPowerGood) begin
					state_next = supply_source_pkg::SUPPLY_FIELD;
					ready_next = 1'b1;
				// [R5] Reuse switch if select returns
				end else if (!syncIn.slaveSelectN || syncIn.memWriteBusy) begin
					// [R6] Write keeps host rail
					state_next = supply_source_pkg::SUPPLY_HOST;
				end else if (count_reg >= CW'(HOLDOFF_CYCLES - 1)) begin
					state_next = supply_source_pkg::SUPPLY_OFF;
					ready_next = 1'b0;
				end
			end
		endcase
		sel_next = selFor(state_next);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= supply_source_pkg::SUPPLY_OFF;
			count_reg <= '0;
			sel_reg <= '{coreOff: 1'b1, fieldSwitch: 1'b0, hostSwitch: 1'b0};
			ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			sel_reg <= sel_next;
			ready_reg <= ready_next;
		end
	end

	// [R10] Buffer size reported to serial side
	assign bufferDepth = 8'(BUFFER_BYTES);
	assign supplySel = sel_reg;
	assign coreReady = ready_reg;

	// ********************************************
	// Checks
	// ********************************************
	int holdCnt;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			holdCnt <= 0;
		end else if (sel_reg.hostSwitch && syncIn.slaveSelectN && !memWriteBusy) begin
			holdCnt <= holdCnt + 1;
		end else begin
			holdCnt <= 0;
		end
	end

	property p_offIdle;
		@(posedge mclk) disable iff (!arst_n)
		(!syncIn.fieldPowerGood && syncIn.slaveSelectN && state_reg == supply_source_pkg::SUPPLY_OFF)
			|=> sel_reg.coreOff;
	endproperty
	a_offIdle: assert property (p_offIdle) else $error("core not off when idle"); // [R1]

	property p_fieldConnect;
		@(posedge mclk) disable iff (!arst_n)
		syncIn.fieldPowerGood |=> sel_reg.fieldSwitch && !sel_reg.hostSwitch;
	endproperty
	a_fieldConnect: assert property (p_fieldConnect) else $error("field rail not chosen"); // [R2]

	property p_exclusive;
		@(posedge mclk) disable iff (!arst_n)
		!(sel_reg.fieldSwitch && sel_reg.hostSwitch);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("both rails connected"); // [R3]

	property p_hostOn;
		@(posedge mclk) disable iff (!arst_n)
		(!syncIn.fieldPowerGood && !syncIn.slaveSelectN) |=> sel_reg.hostSwitch;
	endproperty
	a_hostOn: assert property (p_hostOn) else $error("host switch not closed"); // [R4]

	property p_holdoff;
		@(posedge mclk) disable iff (!arst_n)
		($fell(sel_reg.hostSwitch) && !sel_reg.fieldSwitch) |-> $past(holdCnt) >= HOLDOFF_CYCLES;
	endproperty
	a_holdoff: assert property (p_holdoff) else $error("host switch released early"); // [R5]

	property p_writeHold;
		@(posedge mclk) disable iff (!arst_n)
		(sel_reg.hostSwitch && memWriteBusy && !syncIn.fieldPowerGood) |=> sel_reg.hostSwitch;
	endproperty
	a_writeHold: assert property (p_writeHold) else $error("switch dropped in write"); // [R6]

	sequence s_hostStart;
		$rose(sel_reg.hostSwitch) && !sel_reg.fieldSwitch;
	endsequence
	property p_startup;
		@(posedge mclk) disable iff (!arst_n)
		s_hostStart |-> !coreReady;
	endproperty
	a_startup: assert property (p_startup) else $error("ready before charge time"); // [R7]

	property p_holdCount;
		@(posedge mclk) disable iff (!arst_n)
		holdCnt <= HOLDOFF_CYCLES + 1;
	endproperty
	a_holdCount: assert property (p_holdCount) else $error("hold-off overran"); // [R12]
endmodule : supply_source_manager
`default_nettype wire

// ---- verilog/supply_source_manager_defines.svh ----
/*
 Timing constants for the core supply source manager.
 Assumes the 40 MHz clock on mclk.
*/
`ifndef SUPPLY_SOURCE_MANAGER_DEFINES_SVH
`define SUPPLY_SOURCE_MANAGER_DEFINES_SVH

// ********************************************
// Timing
// ********************************************
`define SSM_CLK_PERIOD_PS 25000
`define SSM_HOLDOFF_NS 700000
`define SSM_HOLDOFF_CYCLES ((`SSM_HOLDOFF_NS * 1000 + `SSM_CLK_PERIOD_PS - 1) / `SSM_CLK_PERIOD_PS)
`define SSM_STARTUP_NS 50000
`define SSM_STARTUP_CYCLES ((`SSM_STARTUP_NS * 1000 + `SSM_CLK_PERIOD_PS - 1) / `SSM_CLK_PERIOD_PS)

`endif

// ---- verilog/supply_source_pkg.sv ----
/*
 Types shared by the supply source manager files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package supply_source_pkg;
	// ********************************************
	// Supply states
	// ********************************************
	typedef enum logic [1:0] {
		SUPPLY_OFF = 2'b00,
		SUPPLY_FIELD = 2'b01,
		SUPPLY_HOST = 2'b10,
		SUPPLY_HOLD = 2'b11
	} supplyState_t;

	typedef struct packed {
		logic coreOff;
		logic fieldSwitch;
		logic hostSwitch;
	} supplySel_t;

	typedef struct packed {
		logic fieldPowerGood;
		logic slaveSelectN;
		logic memWriteBusy;
	} supplyIn_t;
endpackage : supply_source_pkg
